/* File: hdl/cdp_channel.v */
// one counter channel: data port latch and byte order logic
// assumes strobes are single-cycle and qualified by the top decode
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "cdp_defines.vh"

module cdp_channel (
    input wire clk,
    input wire sys_rst,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] wr_data,
    input wire cfg_en,
    input wire [5:0] cfg_mode,
    input wire latch_count,
    input wire latch_status,
    input wire [15:0] live_count,
    input wire out_level,
    output reg [7:0] rd_byte,
    output reg [15:0] load_value_r,
    output reg load_pulse_r
);

// ***************************************
// state
// ***************************************
reg [1:0] rw_mode_r;
reg [3:0] mode_bcd_r;
reg null_r;
reg wptr_r;
reg rptr_r;
reg [7:0] low_hold_r;
reg cnt_held_r;
reg [15:0] cnt_cap_r;
reg cnt_ptr_r;
reg sts_held_r;
reg [7:0] sts_cap_r;

function [7:0] pick_byte;
    input [1:0] rw;
    input ptr;
    input [15:0] val;
    begin
        if (rw == `CDP_RW_MSB || (rw == `CDP_RW_BOTH && ptr)) begin
            pick_byte = val[15:8];
        end else begin
            pick_byte = val[7:0];
        end
    end
endfunction

// ***************************************
// read mux
// ***************************************
always @* begin
    if (sts_held_r) begin
        rd_byte = sts_cap_r;
    end else if (cnt_held_r) begin
        rd_byte = pick_byte(rw_mode_r, cnt_ptr_r, cnt_cap_r);
    end else begin
        rd_byte = pick_byte(rw_mode_r, rptr_r, live_count);
    end
end

// ***************************************
// write, latch and read sequencing
// ***************************************
always @(posedge clk) begin
    if (sys_rst) begin
        rw_mode_r <= `CDP_RST_RW;
        mode_bcd_r <= 4'h0;
        null_r <= 1'b0;
        wptr_r <= 1'b0;
        rptr_r <= 1'b0;
        low_hold_r <= `CDP_RST_BYTE;
        cnt_held_r <= 1'b0;
        cnt_cap_r <= `CDP_RST_COUNT;
        cnt_ptr_r <= 1'b0;
        sts_held_r <= 1'b0;
        sts_cap_r <= `CDP_RST_BYTE;
        load_value_r <= `CDP_RST_COUNT;
        load_pulse_r <= 1'b0;
    end else begin
        load_pulse_r <= 1'b0;
        if (cfg_en) begin
            rw_mode_r <= cfg_mode[5:4];
            mode_bcd_r <= cfg_mode[3:0];
            wptr_r <= 1'b0;
            rptr_r <= 1'b0;
            null_r <= 1'b1;
        end
        if (wr_en) begin
            case (rw_mode_r)
                `CDP_RW_LSB: begin
                    load_value_r <= {8'h00, wr_data};
                    load_pulse_r <= 1'b1;
                    null_r <= 1'b0;
                end
                `CDP_RW_MSB: begin
                    load_value_r <= {wr_data, 8'h00};
                    load_pulse_r <= 1'b1;
                    null_r <= 1'b0;
                end
                `CDP_RW_BOTH: begin
                    wptr_r <= ~wptr_r;
                    if (!wptr_r) begin
                        low_hold_r <= wr_data;
                    end else begin
                        load_value_r <= {wr_data, low_hold_r};
                        load_pulse_r <= 1'b1;
                        null_r <= 1'b0;
                    end
                end
                default: begin
                    wptr_r <= wptr_r;
                end
            endcase
        end
        // capture only when nothing of the same kind is held; later requests dropped
        if (latch_count && !cnt_held_r) begin
            cnt_held_r <= 1'b1;
            cnt_cap_r <= live_count;
            cnt_ptr_r <= 1'b0;
        end
        if (latch_status && !sts_held_r) begin
            sts_held_r <= 1'b1;
            sts_cap_r <= {out_level, null_r, rw_mode_r, mode_bcd_r};
        end
        if (rd_en) begin
            if (sts_held_r) begin
                sts_held_r <= 1'b0;
            end else if (cnt_held_r) begin
                if (rw_mode_r == `CDP_RW_BOTH && !cnt_ptr_r) begin
                    cnt_ptr_r <= 1'b1;
                end else begin
                    cnt_held_r <= 1'b0;
                    cnt_ptr_r <= 1'b0;
                end
            end else if (rw_mode_r == `CDP_RW_BOTH) begin
                rptr_r <= ~rptr_r;
            end
        end
    end
end

endmodule // cdp_channel
`default_nettype wire

/* File: hdl/cdp_defines.vh */
// constants for the counter data port latch block
// assumes byte-wide host port, registers at board offsets
`ifndef CDP_DEFINES_VH
`define CDP_DEFINES_VH

// ***************************************
// addresses
// ***************************************
`define CDP_ADDR_PATTERN_REQUEST_TWO 5'h1a
`define CDP_ADDR_TBASE 5'h1c
`define CDP_ADDR_CMD 5'h1e

// ***************************************
// control word fields
// ***************************************
`define CDP_SEL_HI 7
`define CDP_SEL_LO 6
`define CDP_RW_HI 5
`define CDP_RW_LO 4
`define CDP_RB_COUNT_N 5
`define CDP_RB_STATUS_N 4
`define CDP_RB_C3 3
`define CDP_RB_C2 2
`define CDP_SEL_C2 2'h1
`define CDP_SEL_C3 2'h2
`define CDP_SEL_RB 2'h3
`define CDP_RW_LATCH 2'h0
`define CDP_RW_LSB 2'h1
`define CDP_RW_MSB 2'h2
`define CDP_RW_BOTH 2'h3

// ***************************************
// reset values
// ***************************************
`define CDP_RST_COUNT 16'h0000
`define CDP_RST_BYTE 8'h00
`define CDP_RST_RW 2'h3

`endif

/* File: hdl/cdp_port_latch.v */
// top of the counter data port latch block for counters two and three
// assumes host port on clk; live counts and outputs come from the counters
`timescale 1ns/10ps
`default_nettype none
`include "cdp_defines.vh"

module cdp_port_latch (
    input wire clk,
    input wire sys_rst,
    input wire [4:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output reg [7:0] bus_rdata,
    input wire [15:0] request_two_count_bits,
    input wire [15:0] timebase_count_bits,
    input wire pattern_request_two,
    input wire timebase_out,
    output reg [15:0] request_two_load_r,
    output reg request_two_load_pulse_r,
    output reg [15:0] timebase_load_r,
    output reg timebase_load_pulse_r
);

// ***************************************
// decode
// ***************************************
wire hit_c2 = (bus_addr == `CDP_ADDR_PATTERN_REQUEST_TWO);
wire hit_c3 = (bus_addr == `CDP_ADDR_TBASE);
wire hit_cmd = (bus_addr == `CDP_ADDR_CMD);
wire cmd_wr = bus_wr && hit_cmd;
wire [1:0] counter_choice = bus_wdata[`CDP_SEL_HI:`CDP_SEL_LO];
wire [1:0] byte_access_select = bus_wdata[`CDP_RW_HI:`CDP_RW_LO];
wire is_rb = (counter_choice == `CDP_SEL_RB);
wire is_latch = !is_rb && (byte_access_select == `CDP_RW_LATCH);

function sel_hit;
    input [1:0] want;
    input [1:0] got;
    begin
        sel_hit = (want == got);
    end
endfunction

// latch word vs mode word vs read-back
wire cfg_c2 = cmd_wr && !is_latch && sel_hit(`CDP_SEL_C2, counter_choice);
wire cfg_c3 = cmd_wr && !is_latch && sel_hit(`CDP_SEL_C3, counter_choice);
wire rb_cnt = cmd_wr && is_rb && !bus_wdata[`CDP_RB_COUNT_N];
wire rb_sts = cmd_wr && is_rb && !bus_wdata[`CDP_RB_STATUS_N];
wire lc_c2 = (cmd_wr && is_latch && sel_hit(`CDP_SEL_C2, counter_choice))
    || (rb_cnt && bus_wdata[`CDP_RB_C2]);
wire lc_c3 = (cmd_wr && is_latch && sel_hit(`CDP_SEL_C3, counter_choice))
    || (rb_cnt && bus_wdata[`CDP_RB_C3]);
wire ls_c2 = rb_sts && bus_wdata[`CDP_RB_C2];
wire ls_c3 = rb_sts && bus_wdata[`CDP_RB_C3];

wire [7:0] byte_c2;
wire [7:0] byte_c3;
wire [15:0] ld2;
wire [15:0] ld3;
wire lp2;
wire lp3;

// ***************************************
// channels
// ***************************************
cdp_channel u_pattern_request_two (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(bus_wr && hit_c2),
    .rd_en(bus_rd && hit_c2),
    .wr_data(bus_wdata),
    .cfg_en(cfg_c2),
    .cfg_mode(bus_wdata[5:0]),
    .latch_count(lc_c2),
    .latch_status(ls_c2),
    .live_count(request_two_count_bits),
    .out_level(pattern_request_two),
    .rd_byte(byte_c2),
    .load_value_r(ld2),
    .load_pulse_r(lp2)
);

cdp_channel u_tbase (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(bus_wr && hit_c3),
    .rd_en(bus_rd && hit_c3),
    .wr_data(bus_wdata),
    .cfg_en(cfg_c3),
    .cfg_mode(bus_wdata[5:0]),
    .latch_count(lc_c3),
    .latch_status(ls_c3),
    .live_count(timebase_count_bits),
    .out_level(timebase_out),
    .rd_byte(byte_c3),
    .load_value_r(ld3),
    .load_pulse_r(lp3)
);

// ***************************************
// read data and load outputs
// ***************************************
// unmapped reads give zero; one-byte ports
always @(posedge clk) begin
    if (sys_rst) begin
        bus_rdata <= `CDP_RST_BYTE;
        request_two_load_r <= `CDP_RST_COUNT;
        request_two_load_pulse_r <= 1'b0;
        timebase_load_r <= `CDP_RST_COUNT;
        timebase_load_pulse_r <= 1'b0;
    end else begin
        request_two_load_r <= ld2;
        request_two_load_pulse_r <= lp2;
        timebase_load_r <= ld3;
        timebase_load_pulse_r <= lp3;
        if (bus_rd && hit_c2) begin
            bus_rdata <= byte_c2;
        end else if (bus_rd && hit_c3) begin
            bus_rdata <= byte_c3;
        end else begin
            bus_rdata <= `CDP_RST_BYTE;
        end
    end
end

endmodule // cdp_port_latch
`default_nettype wire

/* File: sim/cdp_counter_model.sv */
// counter model standing behind one data port of the block
// assumes load pulses from the block; bench bends the count by twist
`timescale 1ns/10ps
`default_nettype none
module cdp_counter_model #(
    parameter logic [15:0] START = 16'ha55a
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load_pulse,
    input wire logic [15:0] load_value,
    input wire logic [15:0] twist,
    output logic [15:0] count,
    output logic out_level
);
    logic [15:0] cnt_r;
    always @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= START;
        end else if (load_pulse) begin
            cnt_r <= load_value;
        end
    end
    // no real counting: the bench moves the live value at will
    assign count = cnt_r ^ twist;
    assign out_level = count[15];
endmodule // cdp_counter_model
`default_nettype wire

/* File: sim/cdp_port_latch_checker.sv */
// port relations of the counter data port latch
// assumes one clock and a synchronous reset
`timescale 1ns/10ps
`default_nettype none
module cdp_port_latch_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic [15:0] request_two_count_bits,
    input wire logic [15:0] request_two_load_r,
    input wire logic request_two_load_pulse_r,
    input wire logic [15:0] timebase_load_r,
    input wire logic timebase_load_pulse_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    rdata_idle_a: assert property (
        !$past(bus_rd) |-> bus_rdata == 8'h00) else $error("data no read");
    rd_decode_a: assert property ($past(bus_rd) &&
        $past(bus_addr) != 5'h1a && $past(bus_addr) != 5'h1c
        |-> bus_rdata == 8'h00) else $error("unmapped read not zero");
    r2_load_src_a: assert property (request_two_load_pulse_r |->
        $past(bus_wr, 2) && $past(bus_addr, 2) == 5'h1a)
        else $error("stray load two");
    tb_load_src_a: assert property (timebase_load_pulse_r |->
        $past(bus_wr, 2) && $past(bus_addr, 2) == 5'h1c)
        else $error("stray load three");
    r2_hold_a: assert property (!request_two_load_pulse_r |->
        $stable(request_two_load_r)) else $error("load two moved");
    tb_hold_a: assert property (!timebase_load_pulse_r |->
        $stable(timebase_load_r)) else $error("load three moved");
    rst_clear_a: assert property ($fell(sys_rst) |->
        bus_rdata == 8'h00 && request_two_load_r == 16'h0000 &&
        timebase_load_r == 16'h0000) else $error("reset left state");
    live_first_a: assert property ($fell(sys_rst) && bus_rd &&
        bus_addr == 5'h1a |=> bus_rdata == $past(request_two_count_bits[7:0]))
        else $error("first read not live low");
endmodule // cdp_port_latch_checker
bind cdp_port_latch cdp_port_latch_checker u_chk (.clk(clk),
    .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .request_two_count_bits(request_two_count_bits),
    .request_two_load_r(request_two_load_r),
    .request_two_load_pulse_r(request_two_load_pulse_r),
    .timebase_load_r(timebase_load_r),
    .timebase_load_pulse_r(timebase_load_pulse_r));
`default_nettype wire

/* File: sim/test_counter_data_port_latch.sv */
// self-checking bench for the counter data port latch
// assumes the block's host port and two counter models behind it
`timescale 1ns/10ps
`default_nettype none
module test_counter_data_port_latch;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] bus_addr = 5'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [15:0] twist = 16'h0000;
    logic [7:0] bus_rdata;
    logic [15:0] cnt2, cnt3, ld2, ld3;
    logic out2, out3, pl2, pl3;
    int mismatches = 0;
    int n_compared = 0;
    always #2.5 clk = ~clk;
    cdp_port_latch u_cdp_port_latch (.clk(clk), .sys_rst(sys_rst),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .request_two_count_bits(cnt2), .timebase_count_bits(cnt3),
        .pattern_request_two(out2), .timebase_out(out3),
        .request_two_load_r(ld2), .request_two_load_pulse_r(pl2),
        .timebase_load_r(ld3), .timebase_load_pulse_r(pl3));
    cdp_counter_model u_cdp_counter_model_two (.clk(clk),
        .sys_rst(sys_rst), .load_pulse(pl2), .load_value(ld2),
        .twist(twist), .count(cnt2), .out_level(out2));
    cdp_counter_model u_cdp_counter_model_three (.clk(clk),
        .sys_rst(sys_rst), .load_pulse(pl3), .load_value(ld3),
        .twist(twist), .count(cnt3), .out_level(out3));
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task chk(input logic [16:0] got, input logic [16:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task rd_end(input logic [7:0] e);
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 chk({9'h000, bus_rdata}, {9'h000, e});
    endtask
    task rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        rd_end(e);
    endtask
    // load pulse stands one cycle, just after the edge that follows the
    // closing write's edge; both counters looked at while it stands
    task ld(input logic [16:0] e2, input logic [16:0] e3);
        @(posedge clk);
        #1 chk({pl2, ld2}, e2);
        chk({pl3, ld3}, e3);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        bus_rd <= 1'b1;
        bus_addr <= 5'h1a;
        rd_end(8'h5a);
        rd(5'h1a, 8'ha5);
        wr(5'h1e, 8'h70);
        wr(5'h1a, 8'h34);
        wr(5'h1a, 8'h12);
        ld(17'h11234, 17'h00000);
        rd(5'h1a, 8'h34);
        rd(5'h1a, 8'h12);
        wr(5'h1e, 8'h40);
        // move the live count only once the capture has surely landed
        @(posedge clk);
        twist <= 16'hffff;
        wr(5'h1e, 8'h40);
        rd(5'h1a, 8'h34);
        rd(5'h1a, 8'h12);
        rd(5'h1a, 8'hcb);
        rd(5'h1a, 8'hed);
        wr(5'h1e, 8'h92);
        wr(5'h1c, 8'h80);
        ld(17'h01234, 17'h10080);
        wr(5'h1e, 8'hd8);
        wr(5'h1e, 8'he8);
        @(posedge clk);
        twist <= 16'h0000;
        rd(5'h1c, 8'h92);
        rd(5'h1c, 8'h7f);
        rd(5'h1c, 8'h80);
        rd(5'h1e, 8'h00);
        wr(5'h1e, 8'h60);
        wr(5'h1a, 8'h9c);
        ld(17'h19c00, 17'h00080);
        rd(5'h1a, 8'h9c);
        // status and 16-bit count of counter two in one read-back
        wr(5'h1e, 8'h70);
        wr(5'h1e, 8'hc4);
        rd(5'h1a, 8'hf0);
        rd(5'h1a, 8'h00);
        rd(5'h1a, 8'h9c);
        rd(5'h1a, 8'h00);
        wr(5'h1e, 8'h40);
        // reset in mid-run with a capture held and the pointer on high
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        bus_rd <= 1'b1;
        bus_addr <= 5'h1a;
        rd_end(8'h5a);
        summarize;
    end
    initial begin
        #5000;
        mismatches++;
        summarize;
    end
endmodule // test_counter_data_port_latch
`default_nettype wire
